// file: core/zero_cross_defs.vh
/*
 register map, field positions and reset values of the zero-cross unit.
 assumes a 32-bit axi4-lite slave with one register per aligned word.
*/
`ifndef ZERO_CROSS_DEFS_VH
`define ZERO_CROSS_DEFS_VH

// printed offsets are register indexes; byte address is four times these
`define IDX_DETECTOR_CONTROL  2'h0
`define IDX_RESERVED          2'h1
`define IDX_INT_EDGE_CONTROL  2'h2
`define IDX_DETECTOR_STATUS   2'h3
`define IDX_INT_MASK          3'h4
`define IDX_SLEEP_CONTROL     3'h5

`define CTRL_ENABLE_BIT       0
`define CTRL_FLIP_BIT         3
`define CTRL_PIN_OE_BIT       6
`define CTRL_KEEP_ALIVE_BIT   7
`define STAT_CROSS_BIT        0
`define STAT_STATE_BIT        4

`define RST_DETECTOR_CONTROL  8'h00
`define RST_INT_EDGE_CONTROL  8'h00
`define RST_INT_MASK          8'h01
`define RST_SLEEP_CONTROL     2'h0

`define EDGE_NONE             2'h0
`define EDGE_RISING           2'h1
`define EDGE_FALLING          2'h2
`define EDGE_BOTH             2'h3

`define SLEEP_ACTIVE          2'h0
`define SLEEP_IDLE            2'h1
`define SLEEP_STANDBY         2'h2
`define SLEEP_POWER_DOWN      2'h3

`define SYNC_STAGES           3
`endif

// file: core/state_sync.v
/*
 multi-stage synchroniser for one level.
 assumes the input is asynchronous to aclk; only the last stage is read.
*/
`timescale 1ns/100ps
module state_sync #(
    parameter STAGES = 3
) (
    input  wire aclk,
    input  wire aresetn,
    input  wire async_in,
    output wire sync_out
);
    reg [STAGES-1:0] chain_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            chain_q <= {STAGES{1'b0}};
        end else begin
            chain_q <= {chain_q[STAGES-2:0], async_in};
        end
    end

    assign sync_out = chain_q[STAGES-1];
endmodule

// file: core/zero_cross_unit.v
/*
 zero-cross unit control: registers over axi4-lite, polarity, pin output,
 event output, edge interrupt flag with mask, sleep gating.
 assumes the analog comparator output arrives unsynchronised on cmp_raw
 and the sleep state comes from the power manager on the same clock.
*/
// Operation
// RULE1 - output level goes out asynchronously as level event; no event inputs
// RULE2 - configured crossing sets the crossing flag in status
// RULE3 - interrupt request while edge select not none and flag set; code also needs the mask bit at one
// RULE4 - edge field: 0 none, 1 rising, 2 falling, 3 both
// RULE5 - flip bit inverts output; inverted signal drives edge detection
// RULE6 - idle sleep leaves the unit fully operating
// RULE7 - standby turns unit off unless keep-alive bit is one
// RULE8 - power-down disables unit and its pin drive
// RULE9 - pin output enable routes detector output to the pin
// RULE10 - unit works only while enable bit is one
// RULE11 - state bit shows output after three-stage synchroniser
// RULE12 - writing one clears crossing flag; zero leaves it
// RULE13 - state one when input above reference unless flipped
// RULE14 - a crossing in the clearing cycle keeps the flag set
`timescale 1ns/100ps
`include "zero_cross_defs.vh"
module zero_cross_unit #(
    parameter ADDR_W = 5
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire              cmp_raw,
    input  wire [1:0]        sleep_state,
    output wire              zc_event,
    output wire              zc_pin_out,
    output wire              zc_pin_oe_n,
    output wire              analog_enable,
    output wire              irq,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output wire [1:0]        s_axi_bresp,
    output wire              s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output wire [31:0]       s_axi_rdata,
    output wire [1:0]        s_axi_rresp,
    output wire              s_axi_rvalid,
    input  wire              s_axi_rready
);
    reg  [7:0]        ctrl_q;
    reg  [1:0]        edge_sel_q;
    reg               cross_q;
    reg               mask_q;
    reg               state_prev_q;
    reg               aw_got_q;
    reg               w_got_q;
    reg  [ADDR_W-1:0] aw_addr_q;
    reg  [31:0]       wdata_q;
    reg  [3:0]        wstrb_q;
    reg               bvalid_q;
    reg  [1:0]        bresp_q;
    reg               rvalid_q;
    reg  [31:0]       rdata_q;
    reg  [1:0]        rresp_q;
    reg  [31:0]       rd_word;
    reg               rd_ok;
    reg               wr_ok;
    reg               edge_hit;
    wire              unit_on;
    wire              flipped;
    wire              state_sync;
    wire              do_write;
    wire              cross_clear;
    wire              rise;
    wire              fall;
    wire [2:0]        wr_idx;
    wire [2:0]        rd_idx;

    // unit powered only when enabled and sleep allows it
    assign unit_on = ctrl_q[`CTRL_ENABLE_BIT] &&                      // [RULE10]
                     (sleep_state == `SLEEP_ACTIVE ||
                      sleep_state == `SLEEP_IDLE ||                   // [RULE6]
                      (sleep_state == `SLEEP_STANDBY &&
                       ctrl_q[`CTRL_KEEP_ALIVE_BIT]));               // [RULE7] [RULE8]
    assign analog_enable = unit_on;

    // combinational path keeps the event live while this clock is stopped
    assign flipped  = (cmp_raw ^ ctrl_q[`CTRL_FLIP_BIT]) & unit_on;    // [RULE5] [RULE13]
    assign zc_event = flipped;                                        // [RULE1]
    assign zc_pin_out  = flipped;
    assign zc_pin_oe_n = ~(ctrl_q[`CTRL_PIN_OE_BIT] & unit_on);       // [RULE9] [RULE8]

    state_sync #(
        .STAGES (`SYNC_STAGES)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (flipped),
        .sync_out (state_sync)
    );                                                                // [RULE11]

    // edges taken after flip so polarity also flips the trigger
    assign rise = state_sync & ~state_prev_q;                         // [RULE5]
    assign fall = ~state_sync & state_prev_q;

    always @* begin
        case (edge_sel_q)                                             // [RULE4]
            `EDGE_RISING:  edge_hit = rise;
            `EDGE_FALLING: edge_hit = fall;
            `EDGE_BOTH:    edge_hit = rise | fall;
            default:       edge_hit = 1'b0;
        endcase
    end

    // axi write: address and data accepted in either order
    assign s_axi_awready = ~aw_got_q & ~bvalid_q;
    assign s_axi_wready  = ~w_got_q & ~bvalid_q;
    assign do_write = aw_got_q & w_got_q & ~bvalid_q;
    assign wr_idx   = aw_addr_q[4:2];
    assign rd_idx   = s_axi_araddr[4:2];

    always @* begin
        case (wr_idx)
            {1'b0, `IDX_DETECTOR_CONTROL}, {1'b0, `IDX_RESERVED},
            {1'b0, `IDX_INT_EDGE_CONTROL}, {1'b0, `IDX_DETECTOR_STATUS},
            `IDX_INT_MASK: wr_ok = 1'b1;
            default:       wr_ok = 1'b0;
        endcase
    end

    assign cross_clear = do_write && wstrb_q[0] && wr_idx == {1'b0, `IDX_DETECTOR_STATUS} &&
                         wdata_q[`STAT_CROSS_BIT];                    // [RULE12]

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            aw_addr_q <= {ADDR_W{1'b0}};
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            ctrl_q    <= `RST_DETECTOR_CONTROL;
            edge_sel_q <= 2'h0;
            mask_q    <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q  <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? 2'h0 : 2'h2;
                if (wstrb_q[0]) begin
                    if (wr_idx == {1'b0, `IDX_DETECTOR_CONTROL})
                        ctrl_q <= wdata_q[7:0] & 8'hc9;
                    if (wr_idx == {1'b0, `IDX_INT_EDGE_CONTROL})
                        edge_sel_q <= wdata_q[1:0];
                    if (wr_idx == `IDX_INT_MASK)
                        mask_q <= wdata_q[0];
                end
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // flag: set wins over a simultaneous clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            cross_q      <= 1'b0;
            state_prev_q <= 1'b0;
        end else begin
            state_prev_q <= state_sync;
            if (edge_hit)
                cross_q <= 1'b1;                                      // [RULE2] [RULE14]
            else if (cross_clear)
                cross_q <= 1'b0;                                      // [RULE12]
        end
    end

    // request needs a live edge select as well as the flag
    assign irq = cross_q && edge_sel_q != `EDGE_NONE && mask_q;       // [RULE3]

    always @* begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (rd_idx)
            {1'b0, `IDX_DETECTOR_CONTROL}: rd_word[7:0] = ctrl_q;
            {1'b0, `IDX_RESERVED}:         rd_word = 32'h0000_0000;
            {1'b0, `IDX_INT_EDGE_CONTROL}: rd_word[1:0] = edge_sel_q;
            {1'b0, `IDX_DETECTOR_STATUS}: begin
                rd_word[`STAT_STATE_BIT] = state_sync;                // [RULE11]
                rd_word[`STAT_CROSS_BIT] = cross_q;
            end
            `IDX_INT_MASK:                 rd_word[0] = mask_q;
            `IDX_SLEEP_CONTROL:            rd_word[1:0] = sleep_state;
            default:                       rd_ok = 1'b0;
        endcase
    end

    assign s_axi_arready = ~rvalid_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_ok ? 2'h0 : 2'h2;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;
endmodule

// file: tb/zero_cross_properties.sv
/* port checker of the zero-cross unit.
 assumes it is bound into zero_cross_unit; one clock, sync active-low reset. */
`timescale 1ns/100ps
module zero_cross_properties (
    input logic       aclk,
    input logic       aresetn,
    input logic [1:0] sleep_state,
    input logic       zc_event,
    input logic       zc_pin_out,
    input logic       zc_pin_oe_n,
    input logic       analog_enable,
    input logic       irq,
    input logic       s_axi_awready,
    input logic       s_axi_bvalid,
    input logic       s_axi_bready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    event_pin_a: assert property (zc_event == zc_pin_out)
        else $error("pin differs from event");
    idle_run_a: assert property (sleep_state == 2'h1 && $past(sleep_state) == 2'h0
        |-> analog_enable == $past(analog_enable)) else $error("idle changed unit");
    pdown_off_a: assert property (sleep_state == 2'h3 |-> !analog_enable && zc_pin_oe_n)
        else $error("power-down leaves unit on");
    off_quiet_a: assert property (!analog_enable |-> !zc_event)
        else $error("event while off");
    pin_drive_a: assert property (!zc_pin_oe_n |-> analog_enable)
        else $error("pin driven while off");
    irq_clear_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
        else $error("irq fell without write");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during response");
    cover property ($rose(irq));
    cover property (sleep_state == 2'h3);
    cover property ($rose(s_axi_bvalid));
endmodule
bind zero_cross_unit zero_cross_properties chk (.aclk, .aresetn, .sleep_state, .zc_event,
    .zc_pin_out, .zc_pin_oe_n, .analog_enable, .irq, .s_axi_awready, .s_axi_bvalid,
    .s_axi_bready);

// file: tb/ac_source.sv
/* ac source behind its series resistor, seen as the comparator level.
 assumes the bench moves above_ref just after a clock edge. */
`timescale 1ns/100ps
module ac_source (
    input  logic above_ref,
    input  logic analog_enable,
    output logic cmp_raw
);
    initial cmp_raw = 1'h0;
    // unpowered comparator gives junk, shown inverted rather than a kind zero
    always @(above_ref, analog_enable) cmp_raw <= #7 analog_enable ? above_ref : ~above_ref;
endmodule

// file: tb/tb_top.sv
/* bench of the zero-cross unit: axi4-lite master, scenarios, verdict.
 assumes ac_source drives cmp_raw and the checker is bound in. */
`timescale 1ns/100ps
module tb_top;
    logic        aclk = 1'h0, aresetn = 1'h0, above_ref = 1'h0, cmp_raw, zc_event, zc_pin_out;
    logic        zc_pin_oe_n, analog_enable, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [1:0]  sleep_state = 2'h0, s_axi_bresp, s_axi_rresp, rr;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    int          miscompares = 0, n_compared = 0, cyc = 0;
    zero_cross_unit #(.ADDR_W(5)) DUT (.aclk, .aresetn, .cmp_raw, .sleep_state, .zc_event,
        .zc_pin_out, .zc_pin_oe_n, .analog_enable, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ac_source src (.above_ref, .analog_enable, .cmp_raw);
    always #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask
    // readies sampled at the falling edge, so no race with the slave's own update
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        logic       k;
        logic [2:0] f;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, 24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        do begin
            @(negedge aclk);
            k = w ? s_axi_bvalid : s_axi_rvalid;
            f = {s_axi_awready, s_axi_wready, s_axi_arready};
            rv = s_axi_rdata;
            rr = w ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            s_axi_awvalid <= s_axi_awvalid && !f[2];
            s_axi_wvalid <= s_axi_wvalid && !f[1];
            s_axi_arvalid <= s_axi_arvalid && !f[0];
        end while (!k);
        {s_axi_bready, s_axi_rready} <= 2'h0;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] m, e, input string what);
        bus(1'h0, a, 8'h00);
        chk(what, e, rv & m);
    endtask
    task automatic pins(input logic [3:0] e, input string what);
        @(negedge aclk);
        chk(what, {27'h0, e[3], e[2], e[2:0]},
            {27'h0, irq, zc_event, zc_pin_out, zc_pin_oe_n, analog_enable});
        @(posedge aclk);
    endtask
    task automatic t_reset;
        rdc(5'h00, 32'hff, 32'h00, "ctrl");
        rdc(5'h08, 32'hff, 32'h00, "edge");
        rdc(5'h0c, 32'hff, 32'h00, "status");
        rdc(5'h10, 32'hff, 32'h01, "mask");
        rdc(5'h18, 32'hff, 32'h00, "stray");
        chk("stray resp", 32'h2, {30'h0, rr});
        bus(1'h1, 5'h18, 8'h00);
        chk("stray bresp", 32'h2, {30'h0, rr});
        bus(1'h1, 5'h04, 8'h00);
        chk("reserved bresp", 32'h0, {30'h0, rr});
        bus(1'h1, 5'h00, 8'hff);
        rdc(5'h00, 32'hff, 32'hc9, "ctrl rw");
        bus(1'h1, 5'h00, 8'h00);
    endtask
    task automatic t_state;
        bus(1'h1, 5'h00, 8'h01);
        above_ref <= 1'h1;
        rdc(5'h0c, 32'h10, 32'h00, "state early");
        rdc(5'h0c, 32'h10, 32'h10, "state");
        pins(4'h7, "on");
        bus(1'h1, 5'h00, 8'h09);
        repeat (3) @(posedge aclk);
        rdc(5'h0c, 32'h10, 32'h00, "flip state");
        pins(4'h3, "flip");
        bus(1'h1, 5'h00, 8'h00);
        pins(4'h2, "off");
        above_ref <= 1'h0;
    endtask
    task automatic t_edges;
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            bus(1'h1, 5'h00, 8'h01);
            bus(1'h1, 5'h08, {6'h0, m});
            bus(1'h1, 5'h0c, 8'h01);
            above_ref <= 1'h1;
            repeat (8) @(posedge aclk);
            rdc(5'h0c, 32'h11, {27'h0, 1'b1, 3'h0, m[0]}, "rise flag");
            pins({m[0], 3'h7}, "rise irq");
            if (m == 2'h1) begin
                bus(1'h1, 5'h10, 8'h00);
                pins(4'h7, "masked");
                bus(1'h1, 5'h10, 8'h01);
            end
            bus(1'h1, 5'h0c, 8'h01);
            above_ref <= 1'h0;
            repeat (8) @(posedge aclk);
            rdc(5'h0c, 32'h11, {31'h0, m[1]}, "fall flag");
            bus(1'h1, 5'h0c, 8'h00);
            rdc(5'h0c, 32'h11, {31'h0, m[1]}, "flag kept");
            pins({m[1], 3'h3}, "fall irq");
            bus(1'h1, 5'h0c, 8'h01);
        end
    endtask
    task automatic t_sleep;
        bus(1'h1, 5'h00, 8'hc1);
        sleep_state <= 2'h1;
        pins(4'h1, "idle");
        sleep_state <= 2'h2;
        pins(4'h1, "standby kept");
        bus(1'h1, 5'h00, 8'h41);
        pins(4'h2, "standby off");
        sleep_state <= 2'h3;
        bus(1'h1, 5'h00, 8'hc1);
        pins(4'h2, "power down");
        sleep_state <= 2'h0;
        pins(4'h1, "pin on");
    endtask
    task automatic stop_test;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_state();
        t_edges();
        t_sleep();
        stop_test();
    end
endmodule
